// ### inc/profiler_pkg.sv
// Shared constants, record layout and types for the profiling event records.
package profiler_pkg;

  // ----------------------------------------------------------------------
  // Record layout: 32-byte records, bit positions of every field.
  // ----------------------------------------------------------------------
  localparam int REC_W = 256;
  localparam int EVT_LSB = 0;
  localparam int CORE_LSB = 8;
  localparam int FLAGS_LSB = 16;
  localparam int FIRST_SAMPLE_VALUE_LSB = 32;
  localparam int IP_LSB = 64;
  localparam int SECOND_SAMPLE_VALUE_LSB = 128;
  localparam int STAMP_LSB = 192;
  localparam int FUSED_BIT = 28;
  localparam int TAKEN_BIT = 31;

  // ----------------------------------------------------------------------
  // Event type codes and counter indices.
  // ----------------------------------------------------------------------
  localparam logic [7:0] EVT_VALUE = 8'h01;
  localparam logic [7:0] EVT_INSTR = 8'h02;
  localparam logic [7:0] EVT_BRANCH = 8'h03;
  localparam int NUM_EVT = 3;
  localparam int IDX_VALUE = 0;
  localparam int IDX_INSTR = 1;
  localparam int IDX_BRANCH = 2;
  localparam logic [1:0] USER_PRIV = 2'h3;
  localparam logic [1:0] DEC_ONE = 2'h1;
  localparam logic [1:0] DEC_TWO = 2'h2;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and control field positions.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT0 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_STAMP_BIT = 3;
  localparam int CTRL_CORE_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Retired control transfer classes reported by the pipeline.
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    BR_NONE = 4'h0, BR_NEAR_JMP = 4'h1, BR_JCC = 4'h2, BR_JCXZ = 4'h3,
    BR_LOOP = 4'h4, BR_NEAR_CALL = 4'h5, BR_NEAR_RET = 4'h6,
    BR_FAR = 4'h7, BR_TRAP = 4'h8, BR_INTR = 4'h9, BR_MODE_SWITCH = 4'hA
  } branch_kind_t;

  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_EMIT = 1'b1} emit_state_t;

endpackage

// ### design/event_counter.sv
// Down counter that signals the moment it first becomes negative.
`timescale 1ns/1ps
module event_counter #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic dec_en,
  input wire logic [1:0] dec_amt,
  output logic [W-1:0] value,
  output logic fire
);
  logic [W-1:0] next_value;

  // A negative counter holds until software reloads it, so one crossing
  // yields exactly one record.
  assign next_value = value - W'(dec_amt);
  assign fire = dec_en && !load && !value[W-1] && next_value[W-1];

  // Software loads win over a decrement in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value <= '0;
    end else if (load) begin
      value <= load_value;
    end else if (dec_en && !value[W-1]) begin
      value <= next_value;
    end
  end
endmodule

// ### design/record_fifo.sv
// Record FIFO with valid/ready on both sides and a level output.
`timescale 1ns/1ps
module record_fifo #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = level != (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage has no reset; only the pointers and the level carry state that matters.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and level.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

// ### design/light_profiler.sv
// Profiling event record generator fed by the retirement pipeline.
`timescale 1ns/1ps
module light_profiler
  import profiler_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Retirement pipeline.
  input wire logic ret_valid,
  output logic ret_ready,
  input wire logic [1:0] ret_priv_start,
  input wire logic [1:0] ret_priv_end,
  input wire logic ret_is_value_sample,
  input wire logic ret_legacy,
  input wire logic [15:0] ret_imm,
  input wire logic [31:0] ret_rm_value,
  input wire logic [63:0] ret_reg_value,
  input wire logic [63:0] ret_ip,
  input wire logic [63:0] ret_flag_ip,
  input wire logic [63:0] ret_next_ip,
  input wire logic [3:0] ret_branch_kind,
  input wire logic ret_taken,
  input wire logic ret_fused,
  input wire logic [63:0] stamp_count,
  // Record stream towards the ring-buffer writer.
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [REC_W-1:0] rec_data
);

  // ----------------------------------------------------------------------
  // Decoding helpers.
  // ----------------------------------------------------------------------
  // Far, trap, interrupt and mode-switch classes fall outside the range.
  function automatic logic counted_branch(input logic [3:0] kind);
    return kind >= BR_NEAR_JMP && kind <= BR_NEAR_RET;
  endfunction

  function automatic logic unconditional(input logic [3:0] kind);
    return kind == BR_NEAR_JMP || kind == BR_NEAR_CALL ||
           kind == BR_NEAR_RET;
  endfunction

  // Every field not named is zero from the start.
  function automatic logic [REC_W-1:0] build_record(
    input logic [7:0] code, input logic [7:0] core,
    input logic [15:0] flags, input logic [31:0] first_sample_value,
    input logic [63:0] ip, input logic [63:0] second_sample_value,
    input logic [63:0] stamp);
    logic [REC_W-1:0] r;
    r = '0;
    r[EVT_LSB +: 8] = code;
    r[CORE_LSB +: 8] = core;
    r[FLAGS_LSB +: 16] = flags;
    r[FIRST_SAMPLE_VALUE_LSB +: 32] = first_sample_value;
    r[IP_LSB +: 64] = ip;
    r[SECOND_SAMPLE_VALUE_LSB +: 64] = second_sample_value;
    r[STAMP_LSB +: 64] = stamp;
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  emit_state_t state;
  logic [31:0] ctrl;
  logic [NUM_EVT-1:0] cnt_load;
  logic [NUM_EVT-1:0] cnt_dec;
  logic [1:0] cnt_amt [NUM_EVT];
  logic [CNT_W-1:0] cnt_value [NUM_EVT];
  logic [NUM_EVT-1:0] cnt_fire;
  logic accept;
  logic instr_counted;
  logic [NUM_EVT-1:0] pending;
  logic [NUM_EVT-1:0] next_pending;
  logic [NUM_EVT-1:0] sel;
  logic [7:0] core_cap;
  logic [15:0] imm_cap;
  logic [31:0] rm_cap;
  logic [63:0] ip_cap;
  logic [63:0] br_ip_cap;
  logic [63:0] reg_cap;
  logic [63:0] next_ip_cap;
  logic [63:0] stamp_cap;
  logic fused_cap;
  logic taken_cap;
  logic push_valid;
  logic push_ready;
  logic [REC_W-1:0] push_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic setup;
  logic [7:0] cnt_addr [NUM_EVT];

  // ----------------------------------------------------------------------
  // Counting filters.
  // ----------------------------------------------------------------------
  // A new retirement is taken only while nothing is waiting to be stored,
  // which stalls the pipeline while records are emitted and for as long as a full FIFO blocks one.
  assign ret_ready = state == ST_IDLE;
  assign accept = ret_valid && ret_ready;
  assign instr_counted = ret_priv_start == USER_PRIV &&
                         ret_priv_end == USER_PRIV;

  assign cnt_dec[IDX_VALUE] = accept && ret_is_value_sample &&
                              ctrl[CTRL_EN_LSB + IDX_VALUE];
  assign cnt_amt[IDX_VALUE] = DEC_ONE;
  assign cnt_dec[IDX_INSTR] = accept && instr_counted &&
                              ctrl[CTRL_EN_LSB + IDX_INSTR];
  assign cnt_amt[IDX_INSTR] = ret_fused ? DEC_TWO : DEC_ONE;
  assign cnt_dec[IDX_BRANCH] = accept && counted_branch(ret_branch_kind) &&
                               ctrl[CTRL_EN_LSB + IDX_BRANCH];
  assign cnt_amt[IDX_BRANCH] = DEC_ONE;

  // ----------------------------------------------------------------------
  // One counter per event type.
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++) begin : g_cnt
      assign cnt_addr[gi] = ADDR_CNT0 + 8'(4 * gi);
      assign cnt_load[gi] = psel && penable && pwrite && paddr == cnt_addr[gi];
      event_counter #(.W(CNT_W)) u_cnt (
        .clk(clk),
        .arst_n(arst_n),
        .load(cnt_load[gi]),
        .load_value(pwdata[CNT_W-1:0]),
        .dec_en(cnt_dec[gi]),
        .dec_amt(cnt_amt[gi]),
        .value(cnt_value[gi]),
        .fire(cnt_fire[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Capture of the retirement that produced records.
  // ----------------------------------------------------------------------
  // The pipeline may move on once accepted, so every field a record needs is held here.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_cap <= '0;
      imm_cap <= '0;
      rm_cap <= '0;
      ip_cap <= '0;
      br_ip_cap <= '0;
      reg_cap <= '0;
      next_ip_cap <= '0;
      stamp_cap <= '0;
      fused_cap <= 1'b0;
      taken_cap <= 1'b0;
    end else if (accept) begin
      core_cap <= ctrl[CTRL_CORE_LSB +: 8];
      imm_cap <= ret_imm;
      rm_cap <= ret_rm_value;
      ip_cap <= ret_ip;
      br_ip_cap <= ret_fused ? ret_flag_ip : ret_ip;
      reg_cap <= ret_legacy ? {32'h0000_0000, ret_reg_value[31:0]}
                            : ret_reg_value;
      next_ip_cap <= ret_next_ip;
      stamp_cap <= ctrl[CTRL_STAMP_BIT] ? stamp_count : '0;
      fused_cap <= ret_fused;
      taken_cap <= ret_taken || unconditional(ret_branch_kind);
    end
  end

  // ----------------------------------------------------------------------
  // Emission sequencer.
  // ----------------------------------------------------------------------
  // Lowest event code goes first, one record per cycle.
  assign sel = pending & (~pending + 1'b1);
  assign push_valid = state == ST_EMIT;

  always_comb begin
    next_pending = pending;
    if (accept) begin
      next_pending = cnt_fire;
    end else if (push_valid && push_ready) begin
      next_pending = pending & ~sel;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept && cnt_fire != '0) begin
            state <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (push_ready && next_pending == '0) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Record formation.
  // ----------------------------------------------------------------------
  always_comb begin
    push_data = '0;
    if (sel[IDX_VALUE]) begin
      push_data = build_record(EVT_VALUE, core_cap, imm_cap, rm_cap,
                               ip_cap, reg_cap, stamp_cap);
    end else if (sel[IDX_INSTR]) begin
      push_data = build_record(EVT_INSTR, core_cap, 16'h0000,
                               32'h0000_0000, ip_cap, 64'h0, stamp_cap);
    end else if (sel[IDX_BRANCH]) begin
      push_data = build_record(EVT_BRANCH, core_cap, 16'h0000,
                               32'h0000_0000, br_ip_cap, next_ip_cap,
                               stamp_cap);
      push_data[FUSED_BIT] = fused_cap;
      push_data[TAKEN_BIT] = taken_cap;
    end
  end

  record_fifo #(.WIDTH(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_data),
    .level(fifo_level)
  );

  // ----------------------------------------------------------------------
  // APB slave.
  // ----------------------------------------------------------------------
  // Zero wait states: read data is registered in the setup cycle so that it
  // is stable for the whole access cycle; writes land in the access cycle.
  assign setup = psel && !penable;
  assign pready = 1'b1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
      ctrl <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= 1'b0;
      prdata <= '0;
      if (paddr == ADDR_CTRL) begin
        prdata <= ctrl;
      end else if (paddr == cnt_addr[IDX_VALUE]) begin
        prdata <= 32'(cnt_value[IDX_VALUE]);
      end else if (paddr == cnt_addr[IDX_INSTR]) begin
        prdata <= 32'(cnt_value[IDX_INSTR]);
      end else if (paddr == cnt_addr[IDX_BRANCH]) begin
        prdata <= 32'(cnt_value[IDX_BRANCH]);
      end else if (paddr == ADDR_STATUS) begin
        prdata <= {23'h0, pending, state, 5'(fifo_level)};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_take_fire;
    accept && cnt_fire != '0;
  endsequence

  sequence s_emit_open;
    state == ST_EMIT && pending != '0;
  endsequence

  a_fire_emits: assert property (s_take_fire |=> s_emit_open)
    else $error("record not scheduled after counter crossed zero");
  a_value_code: assert property (push_valid && sel[IDX_VALUE] |->
    push_data[7:0] == EVT_VALUE && push_data[31:16] == imm_cap)
    else $error("value-sample record code or immediate wrong");
  a_stamp_zero: assert property (accept && !ctrl[CTRL_STAMP_BIT] |=>
    stamp_cap == 64'h0)
    else $error("cycle_stamp not zero while stamping disabled");
  a_priv_filter: assert property (accept && ret_priv_start != USER_PRIV &&
    cnt_load == '0 |=> $stable(cnt_value[IDX_INSTR]))
    else $error("instruction entering user level was counted");
  a_fused_two: assert property (cnt_dec[IDX_INSTR] && ret_fused &&
    !cnt_load[IDX_INSTR] && !cnt_value[IDX_INSTR][CNT_W-1] |=>
    cnt_value[IDX_INSTR] == $past(cnt_value[IDX_INSTR]) - 2)
    else $error("fused operation not counted as two");
  a_far_excluded: assert property (accept && !cnt_load[IDX_BRANCH] &&
    ret_branch_kind >= BR_FAR |=> $stable(cnt_value[IDX_BRANCH]))
    else $error("far transfer or trap counted as branch");
  a_fused_flag: assert property (push_valid && sel[IDX_BRANCH] |->
    push_data[FUSED_BIT] == fused_cap && push_data[7:0] == EVT_BRANCH)
    else $error("branch record fused flag wrong");
  a_instr_reserved: assert property (push_valid && sel[IDX_INSTR] |->
    push_data[63:16] == '0 && push_data[191:128] == '0)
    else $error("instruction record reserved bytes not zero");
  a_ready_idle: assert property (s_emit_open |-> !ret_ready)
    else $error("retirement accepted while records pending");
endmodule

// ### verif/retire_model.sv
// Model of the retirement pipeline that feeds the profiler.
`timescale 1ns/1ps
module retire_model
  import profiler_pkg::*;
(
  input wire logic clk,
  input wire logic ret_ready,
  output logic ret_valid,
  output logic [1:0] ret_priv_start,
  output logic [1:0] ret_priv_end,
  output logic ret_is_value_sample,
  output logic ret_legacy,
  output logic [15:0] ret_imm,
  output logic [31:0] ret_rm_value,
  output logic [63:0] ret_reg_value,
  output logic [63:0] ret_ip,
  output logic [63:0] ret_flag_ip,
  output logic [63:0] ret_next_ip,
  output logic [3:0] ret_branch_kind,
  output logic ret_taken,
  output logic ret_fused
);
  // -----------------------------------------------------------------------
  // Idle state.
  // -----------------------------------------------------------------------
  // Every line starts at a known level so the profiler never sees unknowns.
  initial begin
    ret_valid = 1'b0;
    {ret_priv_start, ret_priv_end, ret_is_value_sample, ret_legacy} = '0;
    {ret_imm, ret_rm_value, ret_reg_value, ret_ip} = '0;
    {ret_flag_ip, ret_next_ip, ret_branch_kind, ret_taken, ret_fused} = '0;
  end

  // Presents one retirement after gap + 1 clock edges and holds it until taken.
  // A longer gap models a slow pipeline.
  task automatic present(input logic [1:0] ps, input logic [1:0] pe,
    input logic vs, input logic [3:0] kind, input logic fu,
    input logic tk, input logic [63:0] ip, input int gap, output logic ok);
    int n;
    repeat (gap + 1) @(posedge clk);
    ret_valid <= 1'b1;
    ret_priv_start <= ps;
    ret_priv_end <= pe;
    ret_is_value_sample <= vs;
    ret_legacy <= vs && !ip[0]; // Odd addresses model long mode.
    ret_imm <= 16'hC3A5;
    ret_rm_value <= 32'h1234_ABCD;
    ret_reg_value <= 64'hFEDC_BA98_7654_3210;
    ret_ip <= ip;
    ret_flag_ip <= ip - 64'h4;
    ret_next_ip <= ip + 64'h20;
    ret_branch_kind <= kind;
    ret_taken <= tk;
    ret_fused <= fu;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ret_ready !== 1'b1 && n < 200);
    ok = (ret_ready === 1'b1);
    // Released data and address lines are inverted so a stale capture cannot match by luck.
    ret_valid <= 1'b0;
    ret_imm <= 16'h3C5A;
    ret_rm_value <= 32'hEDCB_5432;
    ret_reg_value <= 64'h0123_4567_89AB_CDEF;
    ret_ip <= ~ip;
    ret_flag_ip <= ~(ip - 64'h4);
    ret_next_ip <= ~(ip + 64'h20);
  endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the profiling event record generator.
`timescale 1ns/1ps
module testbench
  import profiler_pkg::*;
;
  localparam logic [7:0] CORE = 8'h5A;
  localparam logic [63:0] ST = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] IPB = 64'h0000_7FFF_0000_1000;
  localparam logic [255:0] ALL = {256{1'b1}};
  localparam logic [7:0] CNT_I = ADDR_CNT0 + 8'h04;
  localparam logic [7:0] CNT_B = ADDR_CNT0 + 8'h08;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ret_valid, ret_ready, ret_is_value_sample, ret_legacy;
  logic ret_taken, ret_fused, rec_valid, rec_ready;
  logic [1:0] ret_priv_start, ret_priv_end;
  logic [15:0] ret_imm;
  logic [31:0] ret_rm_value;
  logic [63:0] ret_reg_value, ret_ip, ret_flag_ip, ret_next_ip, stamp_count;
  logic [3:0] ret_branch_kind;
  logic [255:0] rec_data;
  int err_total, check_count;

  light_profiler #(.CNT_W(32), .FIFO_DEPTH(16)) light_profiler_inst (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ret_valid, .ret_ready, .ret_priv_start,
    .ret_priv_end, .ret_is_value_sample, .ret_legacy, .ret_imm,
    .ret_rm_value, .ret_reg_value, .ret_ip, .ret_flag_ip, .ret_next_ip,
    .ret_branch_kind, .ret_taken, .ret_fused, .stamp_count, .rec_valid,
    .rec_ready, .rec_data
  );
  retire_model retire_model_inst (
    .clk, .ret_ready, .ret_valid, .ret_priv_start, .ret_priv_end,
    .ret_is_value_sample, .ret_legacy, .ret_imm, .ret_rm_value,
    .ret_reg_value, .ret_ip, .ret_flag_ip, .ret_next_ip, .ret_branch_kind,
    .ret_taken, .ret_fused
  );

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // -----------------------------------------------------------------------
  // Shared tasks.
  // -----------------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [255:0] got, input logic [255:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Builds a record from its fields; the core byte is always CORE.
  function automatic logic [255:0] mk(input logic [7:0] code,
    input logic [15:0] fl, input logic [31:0] d1, input logic [63:0] ip,
    input logic [63:0] d2, input logic [63:0] st);
    return {st, d2, ip, d1, fl, CORE, code};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rq, output logic re);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check(256'h0, 256'h1);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
  endtask

  task automatic pipe(input logic [1:0] ps, input logic [1:0] pe,
    input logic vs, input logic [3:0] kind, input logic fu,
    input logic tk, input logic [63:0] ip, input int gap);
    logic ok;
    retire_model_inst.present(ps, pe, vs, kind, fu, tk, ip, gap, ok);
    if (ok !== 1'b1) begin
      check(256'h0, 256'h1);
      results();
    end
  endtask

  // Takes one record from the stream; the consumer stalls between records.
  task automatic take(input logic [255:0] exp, input logic [255:0] m);
    int n;
    @(posedge clk);
    rec_ready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rec_valid !== 1'b1 && n < 100);
    rec_ready <= 1'b0;
    if (rec_valid !== 1'b1) begin
      check(256'h0, 256'h1);
      results();
    end
    check(rec_data & m, exp & m);
  endtask

  // A pending record shows within three cycles, so four idle ones suffice.
  task automatic none();
    repeat (4) @(posedge clk);
    check(rec_valid, 1'b0);
  endtask

  // -----------------------------------------------------------------------
  // Main sequence.
  // -----------------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, rec_ready} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stamp_count = ST;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    // Unmapped writes are dropped and unmapped reads flag an error.
    wr(8'h40, 32'hFFFF_FFFF);
    wr(ADDR_CTRL, 32'h0000_5A0F);
    apb(1'b0, ADDR_CTRL, 32'h0, q, e);
    check(q, 32'h0000_5A0F);
    apb(1'b0, 8'h40, 32'h0, q, e);
    check({e, q}, {1'b1, 32'h0});
    $display("test registers done");
    wr(ADDR_CNT0, 32'h0);
    wr(CNT_I, 32'h0);
    wr(CNT_B, 32'hFFFF);
    pipe(2'h3, 2'h3, 1'b1, BR_NONE, 1'b0, 1'b0, IPB, 0);
    take(mk(EVT_VALUE, 16'hC3A5, 32'h1234_ABCD, IPB, 64'h7654_3210, ST),
      ALL);
    take(mk(EVT_INSTR, 16'h0, 32'h0, IPB, 64'h0, ST), ALL);
    none();
    wr(ADDR_CNT0, 32'h0);
    pipe(2'h3, 2'h3, 1'b1, BR_NONE, 1'b0, 1'b0, IPB + 64'h1, 0);
    take(mk(EVT_VALUE, 16'hC3A5, 32'h1234_ABCD, IPB + 64'h1,
      64'hFEDC_BA98_7654_3210, ST), ALL);
    $display("test value sample done");
    wr(CNT_I, 32'h0);
    pipe(2'h0, 2'h3, 1'b0, BR_NONE, 1'b0, 1'b0, IPB, 1);
    none();
    pipe(2'h3, 2'h0, 1'b0, BR_NONE, 1'b0, 1'b0, IPB, 0);
    none();
    wr(ADDR_CTRL, 32'h0000_5A07);
    pipe(2'h3, 2'h3, 1'b0, BR_NONE, 1'b0, 1'b0, IPB + 64'h40, 0);
    take(mk(EVT_INSTR, 16'h0, 32'h0, IPB + 64'h40, 64'h0, 64'h0),
      ALL);
    wr(ADDR_CTRL, 32'h0000_5A0F);
    $display("test privilege done");
    wr(CNT_I, 32'hFFFF);
    for (int k = 0; k < 11; k++) begin
      wr(CNT_B, 32'h0);
      pipe(2'h3, 2'h3, 1'b0, 4'(k), 1'b0, 1'b1, IPB + 64'(k), k % 2);
      if (k >= 1 && k <= 6) take(mk(EVT_BRANCH, 16'h8000, 32'h0,
        IPB + 64'(k), IPB + 64'(k) + 64'h20, ST), ALL);
      else none();
    end
    wr(CNT_I, 32'h1);
    wr(CNT_B, 32'h0);
    pipe(2'h3, 2'h3, 1'b0, BR_JCC, 1'b1, 1'b0, IPB, 0);
    take(mk(EVT_INSTR, 16'h0, 32'h0, 64'h0, 64'h0, 64'h0), 256'hFF);
    take(mk(EVT_BRANCH, 16'h1000, 32'h0, IPB - 64'h4, IPB + 64'h20, ST),
      ALL);
    apb(1'b0, CNT_I, 32'h0, q, e);
    check(q, 32'hFFFF_FFFF);
    $display("test branches done");
    // Fill the record buffer with the consumer stalled, then drain it.
    for (int i = 0; i < 17; i++) begin
      wr(CNT_I, 32'h0);
      pipe(2'h3, 2'h3, 1'b0, BR_NONE, 1'b0, 1'b0, IPB + 64'(i), 0);
      if (i == 15) begin
        apb(1'b0, ADDR_STATUS, 32'h0, q, e);
        check(q[4:0], 5'h10);
      end
    end
    repeat (4) @(posedge clk);
    check(ret_ready, 1'b0);
    for (int i = 0; i < 17; i++) begin
      take(mk(EVT_INSTR, 16'h0, 32'h0, IPB + 64'(i), 64'h0, ST),
        ALL);
    end
    none();
    $display("test buffer done");
    results();
  end
endmodule
